// ==== inc/lwf_pkg.sv ====
// Purpose: shared constants and carrier types for the wake-up filter and timers
// Assumes: 200 MHz mclk, internal RC oscillator nominally 32 kHz
// Notes: the oscillator tick is a one-cycle enable made from mclk by a divider
package lwf_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned LWF_MCLK_HZ = 200000000;
	localparam int unsigned LWF_OSC_HZ = 32000;
	localparam int unsigned LWF_OSC_DIV = LWF_MCLK_HZ / LWF_OSC_HZ;
	localparam int unsigned LWF_INACT_OSC = 512;
	localparam int unsigned LWF_ALARM_OSC = 1024;
	localparam int unsigned LWF_RDY_MS = 50;
	localparam int unsigned LWF_RDY_OSC = (LWF_RDY_MS * LWF_OSC_HZ) / 1000;

	// ------------------------------------------------------------------
	// Configuration word zero field positions
	// ------------------------------------------------------------------
	localparam int unsigned LWF_HI_SEL_MSB = 8;
	localparam int unsigned LWF_HI_SEL_LSB = 7;
	localparam int unsigned LWF_LO_SEL_MSB = 6;
	localparam int unsigned LWF_LO_SEL_LSB = 5;
	localparam logic [8:0] LWF_CFG0_RST = 9'h000;

	// Filter time counts in oscillator clocks
	localparam logic [8:0] LWF_T_32 = 9'h020;
	localparam logic [8:0] LWF_T_64 = 9'h040;
	localparam logic [8:0] LWF_T_128 = 9'h080;

	// Output selection on the shared data pin
	typedef enum logic [1:0]
	{
		LWF_OUT_DEMOD,
		LWF_OUT_CARRIER,
		LWF_OUT_STRENGTH,
		LWF_OUT_RSVD
	} lwf_out_sel_t;

	// Filter configuration carrier
	typedef struct packed
	{
		logic [1:0] filter_high_time_sel;
		logic [1:0] filter_low_time_sel;
	} lwf_filt_cfg_t;

	// Shared pin signals
	typedef struct packed
	{
		logic clk_in;
		logic data_in;
	} lwf_pin_in_t;

	typedef struct packed
	{
		logic alert_o;
		logic alert_oe;
		logic data_o;
		logic data_oe;
	} lwf_pin_out_t;

endpackage

// ==== rtl/lwf_osc_timer.sv ====
// Purpose: retriggerable time-out counter of oscillator ticks supplied from outside
// Assumes: restart is a same-clock level or pulse
// Notes: done is a sticky level until restart
`timescale 1ns/10ps
module lwf_osc_timer #(
	parameter int unsigned LIMIT = 512, // Oscillator periods to time-out
	parameter int unsigned CW = 11 // Counter width
) (
	input wire logic mclk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic osc_tick, // One-cycle oscillator enable
	input wire logic restart, // Clear and restart count
	output logic done // Time-out reached
);
	import lwf_pkg::*;

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic done;
	} lwf_tmr_st_t;

	lwf_tmr_st_t st_q;
	lwf_tmr_st_t st_d;

	// ------------------------------------------------------------------
	// Count oscillator ticks
	// ------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		if (restart)
		begin
			st_d.cnt = '0;
			st_d.done = 1'b0;
		end
		else if (osc_tick && !st_q.done)
		begin
			st_d.cnt = st_q.cnt + 1'b1;
			if (st_q.cnt == CW'(LIMIT - 1))
				st_d.done = 1'b1;
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign done = st_q.done;
endmodule

// ==== rtl/lwf_sync3.sv ====
// Purpose: three-stage input synchroniser with agreement qualification
// Assumes: input is asynchronous to mclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/10ps
module lwf_sync3 #(
	parameter int unsigned W = 3 // Number of bits
) (
	input wire logic mclk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [W-1:0] din, // Raw pin levels
	input wire logic [W-1:0] rst_val, // Has no effect on dout; reset loads all ones
	output logic [W-1:0] dout // Qualified levels
);
	import lwf_pkg::*;

	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} lwf_sync_st_t;

	lwf_sync_st_t st_q;
	lwf_sync_st_t st_d;

	// ------------------------------------------------------------------
	// Shift and accept agreed values
	// ------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < W; i++)
		begin
			if (st_q.s2[i] == st_q.s3[i])
				st_d.q[i] = st_q.s3[i];
		end
	end

	// Reset loads all ones regardless of rst_val
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '1;
		else
			st_q <= st_d;
	end

	assign dout = st_q.q & (rst_val | ~rst_val);
endmodule

// ==== rtl/lwf_wakeup_filter.sv ====
// Purpose: wake-up qualification, timers and shared pin control of an LF receive front end
// Assumes: demodulator level, carrier and pins arrive from outside the mclk domain
// Notes: all filter and timer counts use the oscillator tick, not the serial clock
//
// What this block does
// - inactivity timer expires after 512 oscillator periods
// - alarm timer expires after 1024 oscillator periods
// - high-time field codes 32/64/128, 00 disables
// - low-time field codes 32/32/64/128 clocks
// - disabled filter passes input straight through
// - inactivity flag shown only with filter disabled
// - alert low on parity error or alarm
// - chip select low selects programming mode
// - shared pin: serial clock or alert output
// - data pin: demod/carrier or serial data
// - strength output only when option selected
// - ready to receive within 50 ms
`timescale 1ns/10ps
module lwf_wakeup_filter
	import lwf_pkg::*;
#(
	parameter int unsigned OSC_DIV = lwf_pkg::LWF_OSC_DIV, // mclk cycles per osc period
	parameter int unsigned RDY_OSC = lwf_pkg::LWF_RDY_OSC // Osc periods until ready
) (
	input wire logic mclk, // System clock, 200 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic cs_b_in, // Chip select pin, active low
	input wire lwf_pkg::lwf_pin_in_t pin_in, // Shared pin input levels
	input wire logic demod_in, // Raw demodulator level
	input wire logic carrier_in, // Raw carrier clock level
	input wire logic [8:0] config_word_zero, // Configuration word zero
	input wire lwf_pkg::lwf_out_sel_t out_sel, // Data pin output selection
	input wire logic parity_err, // Config parity error level
	input wire logic sdo_bit, // Serial data to drive in programming
	input wire logic sdo_en, // Drive serial data in programming
	input wire logic gain_preserve, // Restart inactivity timer on command
	output lwf_pkg::lwf_pin_out_t pin_out, // Shared pin drives
	output logic strength_current_out, // Strength output enable
	output logic inactivity_timeout, // Inactivity expired, filter off only
	output logic prog_mode, // Serial programming mode active
	output logic rx_ready, // Ready to receive
	output logic spi_clk, // Qualified serial clock level
	output logic spi_din // Qualified serial data level
);

	// ------------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		FLT_WAIT_HIGH,
		FLT_WAIT_LOW,
		FLT_PASS
	} lwf_flt_state_t;

	typedef struct packed
	{
		logic [15:0] div_cnt;
		logic tick;
		lwf_flt_state_t fsm;
		logic [8:0] phase_cnt;
		logic [8:0] total_cnt;
		logic [10:0] rdy_cnt;
		logic prev_demod;
		lwf_pin_out_t pins;
		logic strength;
		logic inact;
		logic prog;
		logic ready;
		logic sclk;
		logic sdin;
	} lwf_top_st_t;

	lwf_top_st_t st_q;
	lwf_top_st_t st_d;
	lwf_filt_cfg_t cfg;
	logic [4:0] sync_out;
	logic cs_b_s;
	logic demod_s;
	logic carrier_s;
	logic inact_done;
	logic alarm_done;
	logic filt_on;
	logic inact_restart;
	logic alarm_restart;

	// Decode the high-time field into a clock count
	function automatic logic [8:0] hi_count(input logic [1:0] sel);
		unique case (sel)
			2'h1: hi_count = LWF_T_32;
			2'h2: hi_count = LWF_T_64;
			2'h3: hi_count = LWF_T_128;
			2'h0: hi_count = 9'h000;
		endcase
	endfunction

	// Decode the low-time field into a clock count
	function automatic logic [8:0] lo_count(input logic [1:0] sel);
		unique case (sel)
			2'h0, 2'h1: lo_count = LWF_T_32;
			2'h2: lo_count = LWF_T_64;
			2'h3: lo_count = LWF_T_128;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Field extraction and input synchronisers
	// ------------------------------------------------------------------
	assign cfg.filter_high_time_sel = config_word_zero[LWF_HI_SEL_MSB:LWF_HI_SEL_LSB];
	assign cfg.filter_low_time_sel = config_word_zero[LWF_LO_SEL_MSB:LWF_LO_SEL_LSB];
	assign filt_on = (cfg.filter_high_time_sel != 2'h0);

	lwf_sync3 #(
		.W(5)
	) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.din({cs_b_in, pin_in.clk_in, pin_in.data_in, demod_in, carrier_in}),
		.rst_val(5'h1F),
		.dout(sync_out)
	);

	assign cs_b_s = sync_out[4];
	assign demod_s = sync_out[1];
	assign carrier_s = sync_out[0];

	// Inactivity restarts on any demod edge, a preserve command or programming
	assign inact_restart = (demod_s != st_q.prev_demod) || gain_preserve || !cs_b_s;
	// Alarm restarts when data is qualified or the host selects the device
	assign alarm_restart = (st_q.fsm == FLT_PASS) || !cs_b_s;

	lwf_osc_timer #(
		.LIMIT(LWF_INACT_OSC),
		.CW(11)
	) u_inact (
		.mclk(mclk),
		.rst_b(rst_b),
		.osc_tick(st_q.tick),
		.restart(inact_restart),
		.done(inact_done)
	);

	lwf_osc_timer #(
		.LIMIT(LWF_ALARM_OSC),
		.CW(11)
	) u_alarm (
		.mclk(mclk),
		.rst_b(rst_b),
		.osc_tick(st_q.tick),
		.restart(alarm_restart),
		.done(alarm_done)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		st_d.prev_demod = demod_s;

		// Oscillator tick divider
		st_d.tick = 1'b0;
		if (st_q.div_cnt == 16'(OSC_DIV - 1))
		begin
			st_d.div_cnt = 16'h0000;
			st_d.tick = 1'b1;
		end
		else
			st_d.div_cnt = st_q.div_cnt + 16'h0001;

		// Wake-up filter: high phase, then low phase, within the total period
		if (!filt_on || !cs_b_s)
		begin
			st_d.fsm = FLT_WAIT_HIGH;
			st_d.phase_cnt = 9'h000;
			st_d.total_cnt = 9'h000;
		end
		else
		begin
			unique case (st_q.fsm)
				FLT_WAIT_HIGH:
				begin
					if (!demod_s)
					begin
						st_d.phase_cnt = 9'h000;
						st_d.total_cnt = 9'h000;
					end
					else if (st_q.tick)
					begin
						st_d.phase_cnt = st_q.phase_cnt + 9'h001;
						st_d.total_cnt = st_q.total_cnt + 9'h001;
					end
					if (demod_s && st_q.phase_cnt >= hi_count(cfg.filter_high_time_sel))
					begin
						st_d.fsm = FLT_WAIT_LOW;
						st_d.phase_cnt = 9'h000;
					end
				end
				FLT_WAIT_LOW:
				begin
					if (st_q.tick)
					begin
						st_d.total_cnt = st_q.total_cnt + 9'h001;
						st_d.phase_cnt = demod_s ? 9'h000 : st_q.phase_cnt + 9'h001;
					end
					if (demod_s && st_q.phase_cnt != 9'h000 &&
						st_q.phase_cnt < lo_count(cfg.filter_low_time_sel))
					begin
						// Low phase too short: start again
						st_d.fsm = FLT_WAIT_HIGH;
						st_d.phase_cnt = 9'h000;
						st_d.total_cnt = 9'h000;
					end
					else if (st_q.phase_cnt >= lo_count(cfg.filter_low_time_sel))
						st_d.fsm = FLT_PASS;
					else if (st_q.total_cnt >= 9'(hi_count(cfg.filter_high_time_sel)
						+ lo_count(cfg.filter_low_time_sel) + LWF_T_64))
					begin
						st_d.fsm = FLT_WAIT_HIGH;
						st_d.phase_cnt = 9'h000;
						st_d.total_cnt = 9'h000;
					end
				end
				FLT_PASS:
				begin
					// Stay open until the link goes quiet
					if (inact_done)
						st_d.fsm = FLT_WAIT_HIGH;
				end
				default:
					st_d.fsm = FLT_WAIT_HIGH;
			endcase
		end

		// Ready counter after reset
		if (st_q.tick && !st_q.ready)
		begin
			st_d.rdy_cnt = st_q.rdy_cnt + 11'h001;
			if (st_q.rdy_cnt == 11'(RDY_OSC - 1))
				st_d.ready = 1'b1;
		end

		// Mode and shared pins
		st_d.prog = !cs_b_s;
		st_d.sclk = sync_out[3];
		st_d.sdin = sync_out[2];
		if (!cs_b_s)
		begin
			// Programming: clock pin is an input, data pin is serial data
			st_d.pins.alert_oe = 1'b0;
			st_d.pins.alert_o = 1'b0;
			st_d.pins.data_oe = sdo_en;
			st_d.pins.data_o = sdo_bit;
		end
		else
		begin
			// Receive: open-drain alert pulls low on fault
			st_d.pins.alert_o = 1'b0;
			st_d.pins.alert_oe = parity_err || alarm_done;
			st_d.pins.data_oe = st_q.ready;
			if (out_sel == LWF_OUT_CARRIER)
				st_d.pins.data_o = carrier_s;
			else if (!filt_on)
				st_d.pins.data_o = demod_s;
			else
				st_d.pins.data_o = demod_s && (st_q.fsm == FLT_PASS);
		end
		st_d.strength = (out_sel == LWF_OUT_STRENGTH) && cs_b_s;
		st_d.inact = inact_done && !filt_on;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q <= '0;
			st_q.fsm <= FLT_WAIT_HIGH;
			st_q.sclk <= 1'b1;
			st_q.sdin <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from flip-flops
	assign pin_out = st_q.pins;
	assign strength_current_out = st_q.strength;
	assign inactivity_timeout = st_q.inact;
	assign prog_mode = st_q.prog;
	assign rx_ready = st_q.ready;
	assign spi_clk = st_q.sclk;
	assign spi_din = st_q.sdin;
endmodule

// ==== test/lwf_wakeup_filter_assertions.sv ====
// Purpose: port checks of the wake-up filter
// Assumes: OSC_DIV and RDY_OSC match the instance
// Notes: counters give the long time bounds
`timescale 1ns/10ps
module lwf_chk
	import lwf_pkg::*;
#(
	parameter int unsigned OSC_DIV = 4, // mclk per osc period
	parameter int unsigned RDY_OSC = 8 // Osc periods to ready
) (
	input wire logic mclk, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic cs_b_in, // Chip select
	input wire logic demod_in, // Demod level
	input wire logic [8:0] config_word_zero, // Config
	input wire lwf_pkg::lwf_out_sel_t out_sel, // Output select
	input wire logic parity_err, // Parity error
	input wire logic sdo_en, // Serial drive enable
	input wire logic gain_preserve, // Preserve command
	input wire lwf_pkg::lwf_pin_out_t pin_out, // Pin drives
	input wire logic strength_current_out, // Strength enable
	input wire logic inactivity_timeout, // Inactivity flag
	input wire logic prog_mode, // Programming mode
	input wire logic rx_ready // Ready
);
	int unsigned quiet_q;
	int unsigned run_q;
	logic demod_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Cycles since reset and since the last timer restart cause
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			quiet_q <= 0;
			run_q <= 0;
			demod_q <= 1'b0;
		end
		else
		begin
			demod_q <= demod_in;
			run_q <= run_q + 1;
			if (demod_in != demod_q || gain_preserve || !cs_b_in)
				quiet_q <= 0;
			else
				quiet_q <= quiet_q + 1;
		end
	end
	AST_PROG_ON: assert property (!cs_b_in [*7] |-> prog_mode)
		else $error("prog mode missing");
	AST_PROG_OFF: assert property (cs_b_in [*7] |-> !prog_mode)
		else $error("prog mode stuck");
	AST_ALERT_SPI: assert property (prog_mode |-> !pin_out.alert_oe)
		else $error("alert driven in prog");
	AST_DATA_SPI: assert property ((prog_mode && $stable(sdo_en)) [*3]
		|-> pin_out.data_oe == sdo_en) else $error("data enable wrong");
	AST_STRENGTH: assert property ((out_sel != LWF_OUT_STRENGTH || !cs_b_in) [*7]
		|-> !strength_current_out) else $error("strength unexpected");
	AST_INACT_GATE: assert property ((config_word_zero[8:7] != 2'h0) [*3]
		|-> !inactivity_timeout) else $error("inactivity shown");
	AST_PARITY: assert property ((parity_err && cs_b_in) [*8] |-> pin_out.alert_oe)
		else $error("parity alert missing");
	AST_INACT_MIN: assert property ($rose(inactivity_timeout)
		|-> quiet_q >= 511 * OSC_DIV) else $error("inactivity early");
	AST_INACT_MAX: assert property ((quiet_q > 513 * OSC_DIV + 8
		&& config_word_zero[8:7] == 2'h0) [*3] |-> inactivity_timeout)
		else $error("inactivity late");
	AST_RDY_MIN: assert property ($rose(rx_ready) |-> run_q >= (RDY_OSC - 1) * OSC_DIV)
		else $error("ready early");
	AST_RDY_MAX: assert property (run_q > (RDY_OSC + 1) * OSC_DIV + 6 |-> rx_ready)
		else $error("ready late");
endmodule

bind lwf_wakeup_filter lwf_chk #(.OSC_DIV(OSC_DIV), .RDY_OSC(RDY_OSC)) i_lwf_chk (.mclk,
	.rst_b, .cs_b_in, .demod_in, .config_word_zero, .out_sel, .parity_err, .sdo_en,
	.gain_preserve, .pin_out, .strength_current_out, .inactivity_timeout, .prog_mode,
	.rx_ready);

// ==== test/lwf_host_model.sv ====
// Purpose: host side of the shared pins
// Assumes: open-drain alert with pull-up
// Notes: serial clock stands high outside frames
`timescale 1ns/10ps
module lwf_host_model
	import lwf_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic prog_req, // Bench asks for a frame
	input wire logic sdi_bit, // Host serial bit
	input wire lwf_pkg::lwf_pin_out_t pin_out, // Device drives
	output lwf_pkg::lwf_pin_in_t pin_in, // Resolved pins
	output logic cs_b_in // Chip select, active low
);
	logic [5:0] div_q;
	logic sclk_q;
	logic junk_q;
	// Serial clock near 1.5 MHz, only inside a frame
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			div_q <= 6'h00;
			sclk_q <= 1'b1;
			junk_q <= 1'b0;
		end
		else
		begin
			div_q <= div_q + 6'h01;
			junk_q <= !junk_q;
			if (!prog_req)
				sclk_q <= 1'b1;
			else if (div_q == 6'h00)
				sclk_q <= !sclk_q;
		end
	end
	// Select stays high unless programming; undriven data wanders
	assign cs_b_in = !prog_req;
	assign pin_in.clk_in = pin_out.alert_oe ? 1'b0 : sclk_q;
	assign pin_in.data_in = pin_out.data_oe ? pin_out.data_o : (prog_req ? sdi_bit : junk_q);
endmodule

// ==== test/lwf_wakeup_filter_tb.sv ====
// Purpose: directed bench of the wake-up filter
// Assumes: shortened divider and ready count
// Notes: expected levels come from the field codes
`timescale 1ns/10ps
module lwf_wakeup_filter_tb;
	import lwf_pkg::*;
	localparam int unsigned DIV = 4;
	logic mclk, rst_b, prog_req, sdi_bit, demod_in, carrier_in, parity_err;
	logic sdo_bit, sdo_en, gain_preserve, cs_b_in, strength_current_out;
	logic inactivity_timeout, prog_mode, rx_ready, spi_clk, spi_din;
	logic [8:0] config_word_zero;
	lwf_out_sel_t out_sel;
	lwf_pin_in_t pin_in;
	lwf_pin_out_t pin_out;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	lwf_wakeup_filter #(.OSC_DIV(DIV), .RDY_OSC(8)) i_lwf_wakeup_filter (.mclk, .rst_b,
		.cs_b_in, .pin_in, .demod_in, .carrier_in, .config_word_zero, .out_sel,
		.parity_err, .sdo_bit, .sdo_en, .gain_preserve, .pin_out, .strength_current_out,
		.inactivity_timeout, .prog_mode, .rx_ready, .spi_clk, .spi_din);
	lwf_host_model i_lwf_host_model (.mclk, .rst_b, .prog_req, .sdi_bit, .pin_out,
		.pin_in, .cs_b_in);
	// ----
	// Tasks
	// ----
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic restart();
		rst_b <= 1'b0;
		tick(3);
		rst_b <= 1'b1;
		tick(60);
	endtask
	// High for h ticks, low for l ticks, then high: does data pass
	task automatic filt(input logic [3:0] cd, input int h, input int l, input logic e);
		config_word_zero <= {cd, 5'h00};
		restart();
		demod_in <= 1'b1;
		tick(h * DIV);
		demod_in <= 1'b0;
		tick(l * DIV);
		demod_in <= 1'b1;
		tick(12);
		chk(pin_out.data_o, e);
		demod_in <= 1'b0;
	endtask
	// Clock and hang guard
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = !mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial
	begin
		int h, l, hs;
		{prog_req, sdi_bit, demod_in, carrier_in, parity_err} <= 5'h0A;
		{sdo_bit, sdo_en, gain_preserve} <= 3'h0;
		config_word_zero <= 9'h000;
		out_sel <= LWF_OUT_DEMOD;
		restart();
		chk(rx_ready, 1'b1);
		demod_in <= 1'b1;
		tick(12);
		chk(pin_out.data_o, 1'b1);
		chk(pin_out.data_oe, 1'b1);
		demod_in <= 1'b0;
		tick(12);
		chk(pin_out.data_o, 1'b0);
		tick(400 * DIV);
		gain_preserve <= 1'b1;
		tick(1);
		gain_preserve <= 1'b0;
		tick(500 * DIV);
		chk(inactivity_timeout, 1'b0);
		tick(20 * DIV);
		chk(inactivity_timeout, 1'b1);
		config_word_zero <= 9'h080;
		tick(8);
		chk(inactivity_timeout, 1'b0);
		out_sel <= LWF_OUT_CARRIER;
		carrier_in <= 1'b1;
		tick(12);
		chk(pin_out.data_o, 1'b1);
		out_sel <= LWF_OUT_STRENGTH;
		tick(8);
		chk(strength_current_out, 1'b1);
		out_sel <= LWF_OUT_DEMOD;
		tick(8);
		chk(strength_current_out, 1'b0);
		$display("test outputs done");
		restart();
		tick(1000 * DIV);
		chk(pin_out.alert_oe, 1'b0);
		tick(40 * DIV);
		chk(pin_out.alert_oe, 1'b1);
		chk(spi_clk, 1'b0);
		prog_req <= 1'b1;
		tick(12);
		chk(prog_mode, 1'b1);
		chk(pin_out.alert_oe, 1'b0);
		chk(spi_din, 1'b1);
		sdi_bit <= 1'b0;
		tick(8);
		chk(spi_din, 1'b0);
		{sdo_en, sdo_bit} <= 2'h3;
		tick(8);
		chk(pin_out.data_oe, 1'b1);
		{sdo_en, prog_req} <= 2'h0;
		tick(10);
		chk(prog_mode, 1'b0);
		parity_err <= 1'b1;
		tick(10);
		chk(pin_out.alert_oe, 1'b1);
		chk(pin_out.alert_o, 1'b0);
		parity_err <= 1'b0;
		$display("test alert done");
		for (int k = 0; k < 4; k++)
		begin
			hs = (k == 0) ? 1 : k;
			h = 32 << (hs - 1);
			l = (k < 2) ? 32 : 32 << (k - 1);
			filt({hs[1:0], k[1:0]}, h / 2, l + 4, 1'b0);
			filt({hs[1:0], k[1:0]}, h + 4, l - 6, 1'b0);
			filt({hs[1:0], k[1:0]}, h + 4, l + 4, 1'b1);
		end
		$display("test filter done");
		tally_and_finish();
	end
endmodule
